// ### child_buffer_manager.sv
// parent-side manager for sleeping end-device children: child table, held unicasts,
// shared broadcast, uplink forwarding and an output buffer toward the radio
// assumes the radio layer reports tx completion (ack or retries exhausted) on tx_done_i
`timescale 1ns/1ps
module child_buffer_manager #(
  parameter int          NCHILD     = child_buffer_pkg::NCHILD_DEF,
  parameter int          NBUF       = child_buffer_pkg::NBUF_DEF,
  parameter int          FIFO_DEPTH = child_buffer_pkg::FIFO_DEF,
  parameter logic [31:0] HOLD_TICKS = child_buffer_pkg::HOLD_TICKS_DEF,
  parameter logic [31:0] POLL_TICKS = child_buffer_pkg::POLL_TICKS_DEF
) (
  input  wire logic                            mclk_i,        // node clock
  input  wire logic                            rst_i,         // sync reset, high
  input  wire logic                            join_valid_i,  // join attempt
  input  wire logic [child_buffer_pkg::ADDR_W-1:0] join_addr_i, // joining child address
  output logic                                 join_ok_o,     // join accepted pulse
  output logic                                 join_refuse_o, // join refused pulse
  output logic                                 capacity_o,    // table has a free entry
  input  wire logic                            poll_valid_i,  // poll request
  input  wire logic [child_buffer_pkg::ADDR_W-1:0] poll_addr_i, // polling child
  output child_buffer_pkg::poll_ack_t          poll_ack_o,    // ack with pending bit
  input  wire logic                            dn_valid_i,    // packet for children
  input  wire child_buffer_pkg::pkt_t          dn_pkt_i,      // its contents
  output logic                                 dn_ready_o,    // always takes
  output logic                                 dn_drop_o,     // packet not stored pulse
  input  wire logic                            up_valid_i,    // packet from a child
  input  wire child_buffer_pkg::pkt_t          up_pkt_i,      // its contents
  output logic                                 up_ready_o,    // uplink slot free
  output logic                                 disc_req_o,    // discovery request pulse
  output logic [child_buffer_pkg::ADDR_W-1:0]  disc_addr_o,   // held uplink destination
  input  wire logic                            route_ok_i,    // route to disc_addr_o known
  output logic                                 out_valid_o,   // packet to transmit
  output child_buffer_pkg::pkt_t               out_pkt_o,     // its contents
  input  wire logic                            out_ready_i,   // radio takes it
  input  wire logic                            tx_done_i      // acked or retries used up
);
  import child_buffer_pkg::*;

  localparam int CW = (NCHILD > 1) ? $clog2(NCHILD) : 1;
  localparam int BW = (NBUF > 1) ? $clog2(NBUF) : 1;
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int FW = $clog2(FIFO_DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(FIFO_DEPTH - 1);
  localparam logic [FW-1:0] CNT_FULL = FW'(FIFO_DEPTH);
  localparam logic [FW-1:0] CNT_ONE  = FW'(1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);
  localparam logic [31:0]   TICK_ONE = 32'h0000_0001;

  typedef struct packed {
    logic [NCHILD-1:0]             c_vld;
    logic [NCHILD-1:0][ADDR_W-1:0] c_addr;
    logic [NCHILD-1:0]             c_flag;
    logic [NCHILD-1:0][31:0]       c_tmr;
    logic [NBUF-1:0]               b_vld;
    pkt_t [NBUF-1:0]               b_pkt;
    logic [NBUF-1:0][31:0]         b_tmr;
    logic                          bc_vld;
    pkt_t                          bc_pkt;
    logic                          up_vld;
    pkt_t                          up_pkt;
    logic                          disc;
    logic                          join_ok;
    logic                          join_ref;
    poll_ack_t                     ack;
    logic                          drop;
    pkt_t [FIFO_DEPTH-1:0]         f_mem;
    logic [PW-1:0]                 f_wp;
    logic [PW-1:0]                 f_rp;
    logic [FW-1:0]                 f_cnt;
    logic                          inflight;
  } state_t;

  state_t            s_reg;
  state_t            s_next;
  logic [NCHILD-1:0] poll_hit;
  logic [NCHILD-1:0] join_hit;
  logic [NCHILD-1:0] dn_hit;
  logic [NBUF-1:0]   held_hit;
  logic              push;
  pkt_t              push_pkt;
  logic [CW-1:0]     ci;
  logic [BW-1:0]     bi;

  function automatic logic [CW-1:0] first_child(input logic [NCHILD-1:0] v);
    first_child = '0;
    for (int k = NCHILD - 1; k >= 0; k--) begin
      if (v[k]) first_child = CW'(k);
    end
  endfunction

  function automatic logic [BW-1:0] first_buf(input logic [NBUF-1:0] v);
    first_buf = '0;
    for (int k = NBUF - 1; k >= 0; k--) begin
      if (v[k]) first_buf = BW'(k);
    end
  endfunction

  // ----------------------------------------------------------------
  // address matching
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCHILD; i++) begin : g_child
    assign poll_hit[i] = s_reg.c_vld[i] && (s_reg.c_addr[i] == poll_addr_i);
    assign join_hit[i] = s_reg.c_vld[i] && (s_reg.c_addr[i] == join_addr_i);
    assign dn_hit[i]   = s_reg.c_vld[i] && (s_reg.c_addr[i] == dn_pkt_i.dest);
  end
  for (genvar j = 0; j < NBUF; j++) begin : g_buf
    assign held_hit[j] = s_reg.b_vld[j] && (s_reg.b_pkt[j].dest == poll_addr_i);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.disc = 1'b0;
    s_next.join_ok = 1'b0;
    s_next.join_ref = 1'b0;
    s_next.ack = '0;
    s_next.drop = 1'b0;
    push = 1'b0;
    push_pkt = '0;
    ci = first_child(poll_hit);
    bi = first_buf(held_hit);

    // timeouts: silent children leave, stale held packets are released
    for (int k = 0; k < NCHILD; k++) begin
      if (s_reg.c_vld[k]) begin
        if (s_reg.c_tmr[k] == '0) begin
          s_next.c_vld[k] = 1'b0;
        end else begin
          s_next.c_tmr[k] = s_reg.c_tmr[k] - TICK_ONE;
        end
      end
    end
    for (int k = 0; k < NBUF; k++) begin
      if (s_reg.b_vld[k]) begin
        if (s_reg.b_tmr[k] == '0) begin
          s_next.b_vld[k] = 1'b0;
        end else begin
          s_next.b_tmr[k] = s_reg.b_tmr[k] - TICK_ONE;
        end
      end
    end

    // poll: acknowledge, then hand over one held item if the output has room
    if (poll_valid_i) begin
      s_next.ack.valid = 1'b1;
      if (|poll_hit) begin
        s_next.c_vld[ci] = 1'b1;
        s_next.c_tmr[ci] = POLL_TICKS - TICK_ONE;
        s_next.ack.pending = (|held_hit) || (s_reg.bc_vld && !s_reg.c_flag[ci]);
        if (s_reg.f_cnt != CNT_FULL) begin
          if (|held_hit) begin
            push = 1'b1;
            push_pkt = s_reg.b_pkt[bi];
            s_next.b_vld[bi] = 1'b0;
          end else if (s_reg.bc_vld && !s_reg.c_flag[ci]) begin
            push = 1'b1;
            push_pkt = s_reg.bc_pkt;
            s_next.c_flag[ci] = 1'b1;
          end
        end
      end
    end

    // join: a new child does not owe the broadcast already held
    if (join_valid_i) begin
      if (|join_hit) begin
        s_next.join_ok = 1'b1;
        s_next.c_tmr[first_child(join_hit)] = POLL_TICKS - TICK_ONE;
      end else if (!(&s_reg.c_vld)) begin
        s_next.join_ok = 1'b1;
        s_next.c_vld[first_child(~s_reg.c_vld)] = 1'b1;
        s_next.c_addr[first_child(~s_reg.c_vld)] = join_addr_i;
        s_next.c_flag[first_child(~s_reg.c_vld)] = 1'b1;
        s_next.c_tmr[first_child(~s_reg.c_vld)] = POLL_TICKS - TICK_ONE;
      end else begin
        s_next.join_ref = 1'b1;
      end
    end

    // downstream packets toward children
    if (dn_valid_i) begin
      if (dn_pkt_i.bcast) begin
        s_next.bc_vld = 1'b1;
        s_next.bc_pkt = dn_pkt_i;
        s_next.c_flag = '0;
      end else if ((|dn_hit) && !(&s_reg.b_vld)) begin
        s_next.b_vld[first_buf(~s_reg.b_vld)] = 1'b1;
        s_next.b_pkt[first_buf(~s_reg.b_vld)] = dn_pkt_i;
        s_next.b_tmr[first_buf(~s_reg.b_vld)] = HOLD_TICKS - TICK_ONE;
      end else begin
        s_next.drop = 1'b1;
      end
    end

    // broadcast is done once every present child holds its flag
    if (s_next.bc_vld && (&(s_next.c_flag | ~s_next.c_vld))) begin
      s_next.bc_vld = 1'b0;
    end

    // uplink: held until a route exists; poll deliveries take the output first
    if (s_reg.up_vld && route_ok_i && !push && (s_reg.f_cnt != CNT_FULL)) begin
      push = 1'b1;
      push_pkt = s_reg.up_pkt;
      s_next.up_vld = 1'b0;
    end
    if (up_valid_i && !s_reg.up_vld) begin
      s_next.up_vld = 1'b1;
      s_next.up_pkt = up_pkt_i;
      s_next.disc = 1'b1;
    end

    // ----------------------------------------------------------------
    // output buffer; one packet in flight, unicast or broadcast, blocks the next until done
    // ----------------------------------------------------------------
    if (tx_done_i) begin
      s_next.inflight = 1'b0;
    end
    if (out_valid_o && out_ready_i) begin
      s_next.inflight = 1'b1;
      s_next.f_rp = (s_reg.f_rp == PTR_LAST) ? '0 : s_reg.f_rp + PTR_ONE;
    end
    if (push) begin
      s_next.f_mem[s_reg.f_wp] = push_pkt;
      s_next.f_wp = (s_reg.f_wp == PTR_LAST) ? '0 : s_reg.f_wp + PTR_ONE;
    end
    if (push && !(out_valid_o && out_ready_i)) begin
      s_next.f_cnt = s_reg.f_cnt + CNT_ONE;
    end else if (!push && out_valid_o && out_ready_i) begin
      s_next.f_cnt = s_reg.f_cnt - CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign join_ok_o     = s_reg.join_ok;
  assign join_refuse_o = s_reg.join_ref;
  assign capacity_o    = !(&s_reg.c_vld);
  assign poll_ack_o    = s_reg.ack;
  assign dn_ready_o    = 1'b1;
  assign dn_drop_o     = s_reg.drop;
  assign up_ready_o    = !s_reg.up_vld;
  assign disc_req_o    = s_reg.disc;
  assign disc_addr_o   = s_reg.up_pkt.dest;
  assign out_valid_o   = (s_reg.f_cnt != '0) && !s_reg.inflight;
  assign out_pkt_o     = s_reg.f_mem[s_reg.f_rp];

endmodule

// ### child_buffer_pkg.sv
// shared types and constants for the parent-side child buffer manager
// assumes one node clock (mclk_i, 40 MHz) and a synchronous active-high reset
//
// Notes on behaviour
// - on a poll, look up that child's held data and acknowledge with pending status
// - child table holds child addresses; capacity reported while an entry is unused
// - with the child table full, further joins are refused
// - packet for a child is stored only if a free buffer exists on arrival
// - stored packet leaves on the child's poll or on hold timeout, whichever first
// - one broadcast buffer is shared by all children
// - a child taking the broadcast on a poll gets its received flag set
// - broadcast is discarded once every child has its flag set
// - a new broadcast replaces an untaken one and clears all flags
// - child packet for a remote node waits for a route, then goes out
// - parent asks for route or short-address discovery for the child's packet
// - each child has its own poll timeout; silent children are removed
// - an outgoing unicast holds its buffer until acknowledged or retries exhausted
package child_buffer_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // node clock and default timeouts
  localparam logic [31:0] CLK_KHZ        = 32'h0000_9C40;   // 40 MHz
  localparam logic [31:0] HOLD_TIME_MS   = 32'h0000_1B58;   // 7000 ms
  localparam logic [31:0] POLL_TIME_MS   = 32'h0000_03E8;   // 1000 ms
  localparam logic [31:0] HOLD_TICKS_DEF = HOLD_TIME_MS * CLK_KHZ;
  localparam logic [31:0] POLL_TICKS_DEF = POLL_TIME_MS * CLK_KHZ;
  localparam int          NCHILD_DEF     = 4;
  localparam int          NBUF_DEF       = 4;
  localparam int          FIFO_DEF       = 2;

  typedef struct packed {
    logic              bcast;
    logic [ADDR_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } pkt_t;

  typedef struct packed {
    logic valid;
    logic pending;
  } poll_ack_t;

endpackage

// ### cbm_monitor.sv
// checker for the child buffer manager, fed only by its top-level ports
// assumes one clock, mclk_i, and synchronous active-high rst_i
`timescale 1ns/1ps
module cbm_monitor (
  input wire logic                                mclk_i,        // clock
  input wire logic                                rst_i,         // reset
  input wire logic                                join_valid_i,  // join
  input wire logic                                join_ok_o,     // accepted
  input wire logic                                join_refuse_o, // refused
  input wire logic                                capacity_o,    // free entry
  input wire logic                                poll_valid_i,  // poll
  input wire child_buffer_pkg::poll_ack_t         poll_ack_o,    // ack
  input wire logic                                dn_valid_i,    // downlink
  input wire child_buffer_pkg::pkt_t              dn_pkt_i,      // downlink pkt
  input wire logic                                dn_ready_o,    // downlink ready
  input wire logic                                dn_drop_o,     // dropped
  input wire logic                                up_valid_i,    // uplink
  input wire child_buffer_pkg::pkt_t              up_pkt_i,      // uplink pkt
  input wire logic                                up_ready_o,    // uplink slot
  input wire logic                                disc_req_o,    // discovery
  input wire logic [child_buffer_pkg::ADDR_W-1:0] disc_addr_o,   // discovery addr
  input wire logic                                out_valid_o,   // out valid
  input wire child_buffer_pkg::pkt_t              out_pkt_o,     // out pkt
  input wire logic                                out_ready_i,   // out ready
  input wire logic                                tx_done_i      // tx done
);
  import child_buffer_pkg::*;
  logic [ADDR_W-1:0] up_dest;
  assign up_dest = up_pkt_i.dest;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_join_ans; join_valid_i |=> join_ok_o != join_refuse_o; endproperty
  a_join_ans: assert property (p_join_ans) else $error("join not answered once");
  property p_cap_ok; join_valid_i && capacity_o |=> join_ok_o; endproperty
  a_cap_ok: assert property (p_cap_ok) else $error("join refused with capacity");
  // judged on the request cycle: a child may time out while the refusal is in flight
  property p_refuse; join_refuse_o |-> $past(join_valid_i) && $past(!capacity_o); endproperty
  a_refuse: assert property (p_refuse) else $error("join refused while not full");
  property p_ack; poll_valid_i |=> poll_ack_o.valid; endproperty
  a_ack: assert property (p_ack) else $error("poll not acknowledged");
  property p_bc_kept; dn_valid_i && dn_pkt_i.bcast |=> !dn_drop_o; endproperty
  a_bc_kept: assert property (p_bc_kept) else $error("broadcast dropped");
  property p_dn_rdy; !dn_valid_i |-> dn_ready_o ##1 !dn_drop_o; endproperty
  a_dn_rdy: assert property (p_dn_rdy) else $error("downlink ready or drop wrong");
  property p_up; up_valid_i && up_ready_o |=> disc_req_o && !up_ready_o && disc_addr_o == $past(up_dest); endproperty
  a_up: assert property (p_up) else $error("uplink not held for discovery");
  property p_take; out_valid_o && out_ready_i |=> !out_valid_o; endproperty
  a_take: assert property (p_take) else $error("valid after take");
  property p_flight; out_valid_o && out_ready_i ##1 !tx_done_i [*2] |=> !out_valid_o; endproperty
  a_flight: assert property (p_flight) else $error("buffer reused before tx done");
  property p_stable; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_pkt_o); endproperty
  a_stable: assert property (p_stable) else $error("held packet changed");
endmodule
bind child_buffer_manager cbm_monitor i_cbm_monitor (.*);

// ### child_model.sv
// sleeping child model: polls its parent and follows the pending bit
// assumes the testbench calls poll() just after a rising edge
`timescale 1ns/1ps
module child_model #(
  parameter int GAP = 4  // poll spacing in cycles, scaled down
) (
  input  wire logic                           mclk_i,       // node clock
  input  wire child_buffer_pkg::poll_ack_t    poll_ack_i,   // parent ack
  output logic                                poll_valid_o, // poll request
  output logic [child_buffer_pkg::ADDR_W-1:0] poll_addr_o   // own address
);
  import child_buffer_pkg::*;
  logic awake = 1'b0;
  initial begin
    poll_valid_o = 1'b0;
    poll_addr_o  = '0;
  end
  task automatic poll(input logic [ADDR_W-1:0] a, output logic pend);
    poll_valid_o = 1'b1;
    poll_addr_o  = a;
    @(posedge mclk_i);
    #1;
    poll_valid_o = 1'b0;
    poll_addr_o  = ~a; // released line must not keep the address
    pend = (poll_ack_i.valid === 1'b1) ? poll_ack_i.pending : 1'bx;
    awake = pend;
    repeat (GAP) @(posedge mclk_i);
    #1;
  endtask
endmodule

// ### tb_top.sv
// self-checking bench for the child buffer manager with small timeouts
// assumes child_model and cbm_monitor are compiled alongside
`timescale 1ns/1ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb_top;
  import child_buffer_pkg::*;
  localparam int          HOLD = 50;
  localparam int          POLL = 300;
  localparam logic [15:0] A = 16'h2120, B = 16'hF220, C = 16'hC100, D = 16'h5750;
  logic              mclk_i = 1'b0, rst_i = 1'b1, join_valid_i = 1'b0, dn_valid_i = 1'b0, up_valid_i = 1'b0;
  logic              route_ok_i = 1'b0, out_ready_i = 1'b0, tx_done_i = 1'b0, poll_valid_i, disc_req_o;
  logic              join_ok_o, join_refuse_o, capacity_o, dn_ready_o, dn_drop_o, up_ready_o, out_valid_o;
  logic [ADDR_W-1:0] join_addr_i = 16'h0000, poll_addr_i, disc_addr_o;
  poll_ack_t         poll_ack_o;
  pkt_t              dn_pkt_i = '0, up_pkt_i = '0, out_pkt_o;
  int                n_fail = 0, total_checks = 0;
  child_buffer_manager #(.NCHILD(2), .NBUF(2), .FIFO_DEPTH(2), .HOLD_TICKS(32'(HOLD)), .POLL_TICKS(32'(POLL)))
    i_child_buffer_manager (.*);
  child_model i_child_model (
    .mclk_i      (mclk_i),
    .poll_ack_i  (poll_ack_o),
    .poll_valid_o(poll_valid_i),
    .poll_addr_o (poll_addr_i)
  );
  always #12.5 mclk_i = ~mclk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic jn(input logic [ADDR_W-1:0] a, input logic ok);
    join_valid_i = 1'b1;
    join_addr_i  = a;
    cyc(1);
    join_valid_i = 1'b0;
    join_addr_i  = ~a;
    `CHK({join_ok_o, join_refuse_o}, {ok, !ok})
    cyc(1);
  endtask
  task automatic send(input pkt_t p, input logic drop);
    dn_valid_i = 1'b1;
    dn_pkt_i   = p;
    cyc(1);
    dn_valid_i = 1'b0;
    dn_pkt_i   = ~p;
    `CHK(dn_drop_o, drop)
    cyc(1);
  endtask
  task automatic pl(input logic [ADDR_W-1:0] a, input logic e);
    logic p;
    i_child_model.poll(a, p);
    `CHK(p, e)
  endtask
  task automatic take(input pkt_t e);
    for (int i = 0; i < 40 && out_valid_o !== 1'b1; i++) cyc(1);
    `CHK({out_valid_o, out_pkt_o}, {1'b1, e})
    out_ready_i = 1'b1;
    cyc(1);
    out_ready_i = 1'b0;
    cyc(3);
    `CHK(out_valid_o, 1'b0)
    tx_done_i = 1'b1;
    cyc(1);
    tx_done_i = 1'b0;
    cyc(1);
  endtask
  task automatic t_join;
    jn(A, 1'b1);
    jn(A, 1'b1);
    jn(B, 1'b1);
    `CHK(capacity_o, 1'b0)
    jn(C, 1'b0);
    $display("test join finished");
  endtask
  task automatic t_uni;
    send('{1'b0, A, 32'h0000_1111}, 1'b0);
    send('{1'b0, C, 32'h0000_2222}, 1'b1);
    pl(A, 1'b1);
    take('{1'b0, A, 32'h0000_1111});
    pl(A, 1'b0);
    $display("test unicast finished");
  endtask
  task automatic t_hold;
    send('{1'b0, B, 32'h0000_0001}, 1'b0);
    send('{1'b0, B, 32'h0000_0002}, 1'b0);
    send('{1'b0, B, 32'h0000_0003}, 1'b1);
    cyc(HOLD + 2);
    pl(B, 1'b0);
    $display("test hold finished");
  endtask
  task automatic t_bcast;
    send('{1'b1, 16'hFFFF, 32'h0000_00B1}, 1'b0);
    pl(A, 1'b1);
    take('{1'b1, 16'hFFFF, 32'h0000_00B1});
    pl(A, 1'b0);
    send('{1'b1, 16'hFFFF, 32'h0000_00B2}, 1'b0);
    pl(A, 1'b1);
    take('{1'b1, 16'hFFFF, 32'h0000_00B2});
    pl(B, 1'b1);
    take('{1'b1, 16'hFFFF, 32'h0000_00B2});
    pl(B, 1'b0);
    $display("test broadcast finished");
  endtask
  task automatic t_stall;
    send('{1'b0, B, 32'h0000_0011}, 1'b0);
    send('{1'b0, B, 32'h0000_0012}, 1'b0);
    pl(B, 1'b1);
    pl(B, 1'b1);
    up_valid_i = 1'b1;
    up_pkt_i   = '{1'b0, D, 32'h0000_0C0C};
    cyc(1);
    up_valid_i = 1'b0;
    up_pkt_i   = '1;
    `CHK({disc_req_o, disc_addr_o, up_ready_o}, {1'b1, D, 1'b0})
    route_ok_i = 1'b1;
    cyc(4);
    `CHK(up_ready_o, 1'b0)
    take('{1'b0, B, 32'h0000_0011});
    take('{1'b0, B, 32'h0000_0012});
    take('{1'b0, D, 32'h0000_0C0C});
    `CHK(up_ready_o, 1'b1)
    route_ok_i = 1'b0;
    $display("test uplink stall finished");
  endtask
  task automatic t_timeout;
    cyc(POLL + 4);
    `CHK(capacity_o, 1'b1)
    jn(C, 1'b1);
    $display("test timeout finished");
  endtask
  // mid-run reset with a unicast and a broadcast held; nothing may survive it
  task automatic t_reset;
    send('{1'b0, C, 32'h0000_0033}, 1'b0);
    send('{1'b1, 16'hFFFF, 32'h0000_00B3}, 1'b0);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    `CHK({capacity_o, up_ready_o, out_valid_o, join_ok_o, disc_addr_o}, {4'b1100, 16'h0000})
    jn(C, 1'b1);
    pl(C, 1'b0);
    $display("test reset finished");
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    #1;
    `CHK({capacity_o, up_ready_o, dn_ready_o, out_valid_o}, 4'b1110)
    rst_i = 1'b0;
    t_join();
    t_uni();
    t_hold();
    t_bcast();
    t_stall();
    t_timeout();
    t_reset();
    close_out();
  end
  initial begin
    #75000;
    n_fail++;
    close_out();
  end
endmodule
